/* File: core/seq_step_pkg.sv */
package seq_step_pkg;
    // function type codes
    localparam logic [4:0] FN_TIMER   = 5'h0E;
    localparam logic [4:0] FN_CLAMP   = 5'h0F;
    localparam logic [4:0] FN_AND     = 5'h10;
    localparam logic [4:0] FN_OR      = 5'h11;
    localparam logic [4:0] FN_XOR     = 5'h12;
    localparam logic [4:0] FN_ANDOR   = 5'h13;
    localparam logic [4:0] FN_SELECT  = 5'h14;
    localparam logic [4:0] FN_BPROBE  = 5'h15;
    localparam logic [4:0] FN_BONE    = 5'h16;
    localparam logic [4:0] FN_BZERO   = 5'h17;
    localparam logic [4:0] FN_SMOOTH  = 5'h18;
    localparam logic [4:0] FN_GAIN    = 5'h19;
    localparam logic [4:0] FN_REGOUT  = 5'h1A;
    localparam logic [4:0] FN_UPCNT   = 5'h1B;
    localparam logic [4:0] FN_DNCNT   = 5'h1C;
    // values and limits
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONE  = 16'h0001;
    localparam logic [15:0] WORD_TWO  = 16'h0002;
    localparam logic [15:0] WORD_MAXP = 16'h7FFF;
    localparam logic [15:0] WORD_NEG1 = 16'hFFFF;
    localparam logic [15:0] BIT_MAX   = 16'h0010;
    localparam logic [15:0] PGAIN_DIV = 16'h0064;
    localparam int          RESET_OUT = 0;
endpackage

/* File: core/seq_step_unit.sv */
`timescale 1ns/1ns
// Function
// - timer compare mode outputs value above max
// - zero word C treated as zero
// - timer overflow restarts count at zero
// - B one stops timer, output zero
// - C one outputs current timer value
// - clamp A between C and B
// - and of A B C, C ignored when zero
// - or of A B C
// - xor of A B C
// - A and B, or C
// - select B when A nonzero, else C
// - probe bit B of A
// - bit index saturates 16, zero gives zero
// - force bit B of A one/zero
// - first order smoothing, constant B loops
// - smoothing runs only when C zero
// - P gain A/100, I gain 1/B loops
// - C selects constant, unipolar, bipolar limit
// - invalid settings output minus one
// - regulator: error, limit, constant 0..32767
// - up counter held zero while B one
// - up edges per C mode, range 0..32767
// - down counter from C, falls on rise
module sequence_function_block_unit (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // step request
    input  wire logic        tick,
    input  wire logic [4:0]  func,
    input  wire logic [15:0] par_a,
    input  wire logic [15:0] par_b,
    input  wire logic [15:0] par_c,
    // step result
    output logic [15:0]      result,
    output logic             result_valid
);
    // whole state of the step unit
    typedef struct packed {
        logic [15:0] result;     // last evaluated output
        logic        valid;      // one tick pulse
        logic [15:0] timer;      // timer accumulator
        logic [31:0] smooth;     // filter state, 16.16
        logic [31:0] integ;      // integral state, 16.16
        logic [15:0] gain_p;     // latched p gain word
        logic [15:0] gain_i;     // latched i divisor
        logic [1:0]  gain_mode;  // latched output mode
        logic        gain_ok;    // gain settings valid
        logic [15:0] upcnt;      // up counter
        logic [15:0] dncnt;      // down counter
        logic        prev_a;     // A bit 0 one tick ago
    } state_t;

    state_t st;       // registered state
    state_t next_st;  // next state

    // edge detect on A bit 0 sampled at last tick
    logic a_now;
    logic rise;
    logic fall;
    assign a_now = par_a[0];
    assign rise  = a_now & ~st.prev_a;
    assign fall  = ~a_now & st.prev_a;

    // bit index saturation, shared by the three bit functions
    logic [15:0] bidx;
    logic [15:0] bmask;
    assign bidx  = ($signed(par_b) > $signed(seq_step_pkg::BIT_MAX)) ? seq_step_pkg::BIT_MAX : par_b;
    assign bmask = (bidx == seq_step_pkg::WORD_ZERO) ? 16'h0000 : (16'h0001 << (bidx[4:0] - 5'h01));

    // signed scratch for filter and regulator
    logic signed [31:0] a_fix;
    logic signed [31:0] diff;
    logic signed [31:0] pterm;
    logic signed [31:0] sum;
    logic signed [31:0] lim;
    logic signed [31:0] lo;

    // evaluation of one step
    always_comb begin
        next_st       = st;
        next_st.valid = 1'b0;
        a_fix = {par_a, 16'h0000};
        diff  = 32'sh0;
        pterm = 32'sh0;
        sum   = 32'sh0;
        lim   = 32'sh0;
        lo    = 32'sh0;
        if (tick) begin
            next_st.valid  = 1'b1;
            next_st.prev_a = a_now;
            case (func)
                seq_step_pkg::FN_TIMER: begin
                    if (par_b == seq_step_pkg::WORD_ONE) begin
                        // stopped: output zero, count held
                        next_st.result = seq_step_pkg::WORD_ZERO;
                    end else begin
                        // wrap to zero past the maximum
                        if ($signed(st.timer) > $signed(par_a)) begin
                            next_st.timer = seq_step_pkg::WORD_ZERO;
                        end else begin
                            next_st.timer = st.timer + 16'h0001;
                        end
                        if (par_c == seq_step_pkg::WORD_ONE) begin
                            next_st.result = st.timer;
                        end else begin
                            // C of 0x0000 lands here as compare mode
                            next_st.result = ($signed(st.timer) > $signed(par_a)) ? 16'h0001
                                                                                  : 16'h0000;
                        end
                    end
                end
                seq_step_pkg::FN_CLAMP: begin
                    // bound order is up to whoever configures it
                    if ($signed(par_a) > $signed(par_b)) begin
                        next_st.result = par_b;
                    end else if ($signed(par_a) < $signed(par_c)) begin
                        next_st.result = par_c;
                    end else begin
                        next_st.result = par_a;
                    end
                end
                seq_step_pkg::FN_AND: begin
                    next_st.result = (par_c == seq_step_pkg::WORD_ZERO) ? (par_a & par_b)
                                                                         : (par_a & par_b & par_c);
                end
                seq_step_pkg::FN_OR: begin
                    next_st.result = par_a | par_b | par_c;
                end
                seq_step_pkg::FN_XOR: begin
                    next_st.result = par_a ^ par_b ^ par_c;
                end
                seq_step_pkg::FN_ANDOR: begin
                    next_st.result = (par_a & par_b) | par_c;
                end
                seq_step_pkg::FN_SELECT: begin
                    // any nonzero selector picks B
                    next_st.result = (par_a != seq_step_pkg::WORD_ZERO) ? par_b : par_c;
                end
                seq_step_pkg::FN_BPROBE: begin
                    next_st.result = ((par_a & bmask) != 16'h0000) ? 16'h0001 : 16'h0000;
                end
                seq_step_pkg::FN_BONE: begin
                    next_st.result = (bmask == 16'h0000) ? 16'h0000 : (par_a | bmask);
                end
                seq_step_pkg::FN_BZERO: begin
                    next_st.result = (bmask == 16'h0000) ? 16'h0000 : (par_a & ~bmask);
                end
                seq_step_pkg::FN_SMOOTH: begin
                    if (par_c == seq_step_pkg::WORD_ZERO) begin
                        // y += (a - y) / B; B of one or below passes A straight
                        diff = a_fix - $signed(st.smooth);
                        if ($signed(par_b) > 16'sh0001) begin
                            next_st.smooth = st.smooth + 32'(diff / $signed({16'h0000, par_b}));
                        end else begin
                            next_st.smooth = a_fix;
                        end
                    end
                    next_st.result = next_st.smooth[31:16];
                end
                seq_step_pkg::FN_GAIN: begin
                    // latch gains for the regulator step that follows
                    next_st.gain_p    = par_a;
                    next_st.gain_i    = par_b;
                    next_st.gain_mode = par_c[1:0];
                    next_st.gain_ok   = ($signed(par_a) >= 0) && ($signed(par_b) > 0)
                                        && ($unsigned(par_c) <= seq_step_pkg::WORD_TWO);
                    next_st.result    = next_st.gain_ok ? seq_step_pkg::WORD_ZERO
                                                        : seq_step_pkg::WORD_NEG1;
                end
                seq_step_pkg::FN_REGOUT: begin
                    // relies on the gain step right before it
                    if (!st.gain_ok || $signed(par_c) < 0 || $signed(par_b) < 0) begin
                        next_st.result = seq_step_pkg::WORD_NEG1;
                    end else if (st.gain_mode == 2'd0) begin
                        next_st.result = par_c;
                    end else begin
                        pterm = ($signed(a_fix) / $signed({16'h0000, seq_step_pkg::PGAIN_DIV}))
                                * $signed({16'h0000, st.gain_p});
                        next_st.integ = st.integ + 32'(a_fix / $signed({16'h0000, st.gain_i}));
                        lim = $signed({par_b, 16'h0000});
                        lo  = (st.gain_mode == 2'd1) ? 32'sh0 : -lim;
                        // anti windup: integral held inside limits
                        if ($signed(next_st.integ) > lim) next_st.integ = lim;
                        if ($signed(next_st.integ) < lo)  next_st.integ = lo;
                        sum = pterm + $signed(next_st.integ);
                        if (sum > lim) sum = lim;
                        if (sum < lo)  sum = lo;
                        next_st.result = sum[31:16];
                    end
                end
                seq_step_pkg::FN_UPCNT: begin
                    if (par_b == seq_step_pkg::WORD_ONE) begin
                        next_st.upcnt = seq_step_pkg::WORD_ZERO;
                    end else if (((par_c == seq_step_pkg::WORD_ZERO) && rise) ||
                                 ((par_c == seq_step_pkg::WORD_ONE) && fall) ||
                                 ((par_c == seq_step_pkg::WORD_TWO) && (rise || fall))) begin
                        // saturate at top of range
                        if (st.upcnt < seq_step_pkg::WORD_MAXP) begin
                            next_st.upcnt = st.upcnt + 16'h0001;
                        end
                    end
                    next_st.result = next_st.upcnt;
                end
                seq_step_pkg::FN_DNCNT: begin
                    if (par_b == seq_step_pkg::WORD_ONE) begin
                        next_st.dncnt = par_c;
                    end else if (rise && (st.dncnt != 16'h0000)) begin
                        // stops at zero, no wrap
                        next_st.dncnt = st.dncnt - 16'h0001;
                    end
                    next_st.result = next_st.dncnt;
                end
                default: begin
                    next_st.result = seq_step_pkg::WORD_ZERO;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign result       = st.result;
    assign result_valid = st.valid;

    // timer stop gives zero output next cycle
    property p_timer_stop;
        @(posedge clk) disable iff (srst)
        (tick && func == seq_step_pkg::FN_TIMER && par_b == 16'h0001) |=> (result == 16'h0000);
    endproperty
    a_timer_stop: assert property (p_timer_stop) else $error("timer stop not zero");

    property p_clamp;
        @(posedge clk) disable iff (srst)
        (tick && func == seq_step_pkg::FN_CLAMP && $signed(par_a) > $signed(par_b)) |=> (result == $past(par_b));
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp upper wrong");

    property p_and;
        @(posedge clk) disable iff (srst)
        (tick && func == seq_step_pkg::FN_AND && par_c != 16'h0000)
        |=> (result == ($past(par_a) & $past(par_b) & $past(par_c)));
    endproperty
    a_and: assert property (p_and) else $error("and wrong");

    property p_xor;
        @(posedge clk) disable iff (srst)
        (tick && func == seq_step_pkg::FN_XOR) |=> (result == ($past(par_a) ^ $past(par_b) ^ $past(par_c)));
    endproperty
    a_xor: assert property (p_xor) else $error("xor wrong");

    property p_sel;
        @(posedge clk) disable iff (srst)
        (tick && func == seq_step_pkg::FN_SELECT && par_a == 16'h0000) |=> (result == $past(par_c));
    endproperty
    a_sel: assert property (p_sel) else $error("select wrong");

    property p_bit_zero;
        @(posedge clk) disable iff (srst)
        (tick && (func == seq_step_pkg::FN_BONE || func == seq_step_pkg::FN_BPROBE) && par_b == 16'h0000)
        |=> (result == 16'h0000);
    endproperty
    a_bit_zero: assert property (p_bit_zero) else $error("bit index zero not zero");

    property p_up_hold;
        @(posedge clk) disable iff (srst)
        (tick && func == seq_step_pkg::FN_UPCNT && par_b == 16'h0001) |=> (result == 16'h0000);
    endproperty
    a_up_hold: assert property (p_up_hold) else $error("up counter not held");

    sequence s_dn_load;
        tick && func == seq_step_pkg::FN_DNCNT && par_b == 16'h0001;
    endsequence
    property p_dn_load;
        @(posedge clk) disable iff (srst)
        s_dn_load |=> (result == $past(par_c)) && result_valid;
    endproperty
    a_dn_load: assert property (p_dn_load) else $error("down counter load wrong");

    property p_valid;
        @(posedge clk) disable iff (srst)
        tick |=> result_valid ##1 (result_valid == $past(tick));
    endproperty
    a_valid: assert property (p_valid) else $error("valid not tied to tick");
endmodule

/* File: dv/tb_sequence_function_block_unit.sv */
`timescale 1ns/1ns
module tb_sequence_function_block_unit;
    // clock, reset, step inputs
    logic        clk;
    logic        srst;
    logic        tick;
    logic [4:0]  func;
    logic [15:0] par_a;
    logic [15:0] par_b;
    logic [15:0] par_c;
    // outputs and bookkeeping
    logic [15:0] result;
    logic        result_valid;
    int          err_count;
    int          n_compared;
    int          cycles;

    sequence_function_block_unit sequence_function_block_unit_i (
        .clk          (clk),
        .srst         (srst),
        .tick         (tick),
        .func         (func),
        .par_a        (par_a),
        .par_b        (par_b),
        .par_c        (par_c),
        .result       (result),
        .result_valid (result_valid)
    );

    // free running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // hang guard; the counter saturation loop dominates the run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_count = err_count + 1;
            close_out();
        end
    end

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // one tick; valid pulse is looked at in the cycle it stands
    task automatic step(input logic [4:0] f, input logic [15:0] a, input logic [15:0] b,
                        input logic [15:0] c, output logic [15:0] r);
        @(posedge clk);
        #1;
        func = f;
        par_a = a;
        par_b = b;
        par_c = c;
        tick = 1'b1;
        @(posedge clk);
        #1;
        tick = 1'b0;
        check({15'h0000, result_valid}, 16'h0001);
        r = result;
    endtask

    task automatic t(input logic [4:0] f, input logic [15:0] a, input logic [15:0] b,
                     input logic [15:0] c, input logic [15:0] exp);
        logic [15:0] r;
        step(f, a, b, c, r);
        check(r, exp);
    endtask

    task automatic test_logic();
        t(seq_step_pkg::FN_AND, 16'hF0F0, 16'hFF00, 16'h0000, 16'hF000);
        t(seq_step_pkg::FN_AND, 16'hF0F0, 16'hFF00, 16'h000F, 16'h0000);
        t(seq_step_pkg::FN_OR, 16'hF0F0, 16'hFF00, 16'h0000, 16'hFFF0);
        t(seq_step_pkg::FN_OR, 16'hF0F0, 16'hFF00, 16'h000F, 16'hFFFF);
        t(seq_step_pkg::FN_XOR, 16'hF0F0, 16'hFF00, 16'h0000, 16'h0FF0);
        t(seq_step_pkg::FN_XOR, 16'hF0F0, 16'hFF00, 16'h000F, 16'h0FFF);
        t(seq_step_pkg::FN_ANDOR, 16'hF0F0, 16'hFF00, 16'h0000, 16'hF000);
        t(seq_step_pkg::FN_ANDOR, 16'hF0F0, 16'hFF00, 16'h000F, 16'hF00F);
        // valid drops after its single cycle
        @(posedge clk);
        #1;
        check({15'h0000, result_valid}, 16'h0000);
        t(5'h00, 16'h1234, 16'h1234, 16'h1234, 16'h0000);
        $display("logic done");
    endtask

    task automatic test_clamp_select();
        t(seq_step_pkg::FN_CLAMP, 16'h0032, 16'h0064, 16'hFF9C, 16'h0032);
        t(seq_step_pkg::FN_CLAMP, 16'h0064, 16'h0064, 16'hFF9C, 16'h0064);
        t(seq_step_pkg::FN_CLAMP, 16'h00C8, 16'h0064, 16'hFF9C, 16'h0064);
        t(seq_step_pkg::FN_CLAMP, 16'hFF38, 16'h0064, 16'hFF9C, 16'hFF9C);
        t(seq_step_pkg::FN_SELECT, 16'h0001, 16'hAAAA, 16'h5555, 16'hAAAA);
        t(seq_step_pkg::FN_SELECT, 16'h0000, 16'hAAAA, 16'h5555, 16'h5555);
        $display("clamp select done");
    endtask

    task automatic test_bits();
        t(seq_step_pkg::FN_BPROBE, 16'h8001, 16'h0001, 16'h0000, 16'h0001);
        t(seq_step_pkg::FN_BPROBE, 16'h8001, 16'h0002, 16'h0000, 16'h0000);
        t(seq_step_pkg::FN_BPROBE, 16'h8001, 16'h0014, 16'h0000, 16'h0001);
        t(seq_step_pkg::FN_BPROBE, 16'h8001, 16'h0000, 16'h0000, 16'h0000);
        t(seq_step_pkg::FN_BONE, 16'h0000, 16'h0003, 16'hFFFF, 16'h0004);
        t(seq_step_pkg::FN_BONE, 16'h0000, 16'h0011, 16'h0000, 16'h8000);
        t(seq_step_pkg::FN_BONE, 16'h1234, 16'h0000, 16'h0000, 16'h0000);
        t(seq_step_pkg::FN_BZERO, 16'hFFFF, 16'h0001, 16'hFFFF, 16'hFFFE);
        t(seq_step_pkg::FN_BZERO, 16'hFFFF, 16'h0010, 16'h0000, 16'h7FFF);
        t(seq_step_pkg::FN_BZERO, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000);
        $display("bits done");
    endtask

    // period between compare hits fixed by the wrap to zero
    task automatic test_timer();
        logic [15:0] r;
        logic [15:0] v;
        int hit[$];
        t(seq_step_pkg::FN_TIMER, 16'h0000, 16'h0001, 16'h0001, 16'h0000);
        step(seq_step_pkg::FN_TIMER, 16'h0000, 16'h0000, 16'h0001, v);
        t(seq_step_pkg::FN_TIMER, 16'h0000, 16'h0000, 16'h0001, v + 16'h0001);
        for (int k = 0; k < 16; k++) begin
            step(seq_step_pkg::FN_TIMER, 16'h0003, 16'h0000, 16'h0000, r);
            if (r === 16'h0001) hit.push_back(k);
        end
        check(16'(hit.size() >= 3), 16'h0001);
        if (hit.size() >= 3) begin
            check(16'(hit[2] - hit[1]), 16'(hit[1] - hit[0]));
            check(16'(hit[1] - hit[0] inside {4, 5}), 16'h0001);
        end
        $display("timer done");
    endtask

    task automatic test_smoother();
        logic [15:0] r;
        t(seq_step_pkg::FN_SMOOTH, 16'h03E8, 16'h0001, 16'h0000, 16'h03E8);
        for (int k = 0; k < 4; k++) step(seq_step_pkg::FN_SMOOTH, 16'h0000, 16'h0004, 16'h0000, r);
        check(16'(r >= 16'h012C && r <= 16'h0154), 16'h0001);
        t(seq_step_pkg::FN_SMOOTH, 16'h0000, 16'h0004, 16'h0001, r);
        $display("smoother done");
    endtask

    task automatic test_regulator();
        t(seq_step_pkg::FN_GAIN, 16'hFFFF, 16'h000A, 16'h0000, 16'hFFFF);
        t(seq_step_pkg::FN_REGOUT, 16'h0010, 16'h0064, 16'h007B, 16'hFFFF);
        t(seq_step_pkg::FN_GAIN, 16'h0064, 16'h000A, 16'h0000, 16'h0000);
        t(seq_step_pkg::FN_REGOUT, 16'h0010, 16'h0064, 16'h007B, 16'h007B);
        t(seq_step_pkg::FN_GAIN, 16'h0064, 16'h03E8, 16'h0001, 16'h0000);
        t(seq_step_pkg::FN_REGOUT, 16'hFFCE, 16'h0064, 16'h0000, 16'h0000);
        t(seq_step_pkg::FN_GAIN, 16'h0064, 16'h03E8, 16'h0002, 16'h0000);
        t(seq_step_pkg::FN_REGOUT, 16'h01F4, 16'h0064, 16'h0000, 16'h0064);
        t(seq_step_pkg::FN_GAIN, 16'h0064, 16'h03E8, 16'h0005, 16'hFFFF);
        // negative constant output is out of range
        t(seq_step_pkg::FN_GAIN, 16'h0064, 16'h03E8, 16'h0000, 16'h0000);
        t(seq_step_pkg::FN_REGOUT, 16'h0010, 16'h0064, 16'h8000, 16'hFFFF);
        // zero p gain: integral alone adds A/B per tick, half left over from before
        t(seq_step_pkg::FN_GAIN, 16'h0000, 16'h0004, 16'h0002, 16'h0000);
        t(seq_step_pkg::FN_REGOUT, 16'h0008, 16'h0064, 16'h0000, 16'h0002);
        t(seq_step_pkg::FN_GAIN, 16'h0000, 16'h0004, 16'h0002, 16'h0000);
        t(seq_step_pkg::FN_REGOUT, 16'h0008, 16'h0064, 16'h0000, 16'h0004);
        $display("regulator done");
    endtask

    // edges judged against par_a bit 0 of the previous tick
    task automatic test_counters();
        logic [15:0] r;
        t(seq_step_pkg::FN_UPCNT, 16'h0000, 16'h0001, 16'h0000, 16'h0000);
        t(seq_step_pkg::FN_UPCNT, 16'h0001, 16'h0000, 16'h0000, 16'h0001);
        t(seq_step_pkg::FN_UPCNT, 16'h0000, 16'h0000, 16'h0000, 16'h0001);
        t(seq_step_pkg::FN_UPCNT, 16'h0001, 16'h0000, 16'h0001, 16'h0001);
        t(seq_step_pkg::FN_UPCNT, 16'h0000, 16'h0000, 16'h0001, 16'h0002);
        t(seq_step_pkg::FN_UPCNT, 16'h0001, 16'h0000, 16'h0002, 16'h0003);
        t(seq_step_pkg::FN_UPCNT, 16'h0000, 16'h0001, 16'h0002, 16'h0000);
        for (int k = 0; k < 32770; k++) step(seq_step_pkg::FN_UPCNT, 16'(k + 1), 16'h0000, 16'h0002, r);
        check(r, seq_step_pkg::WORD_MAXP);
        t(seq_step_pkg::FN_DNCNT, 16'h0000, 16'h0001, 16'h0002, 16'h0002);
        t(seq_step_pkg::FN_DNCNT, 16'h0001, 16'h0000, 16'h0002, 16'h0001);
        t(seq_step_pkg::FN_DNCNT, 16'h0000, 16'h0000, 16'h0002, 16'h0001);
        t(seq_step_pkg::FN_DNCNT, 16'h0001, 16'h0000, 16'h0002, 16'h0000);
        $display("counters done");
    endtask

    // mid-run reset clears the saturated up counter and edge history
    task automatic test_reset();
        logic [15:0] r;
        step(seq_step_pkg::FN_UPCNT, 16'h0000, 16'h0000, 16'h0000, r);
        check(r, seq_step_pkg::WORD_MAXP);
        @(posedge clk);
        #1;
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        check(result, 16'h0000);
        check({15'h0000, result_valid}, 16'h0000);
        t(seq_step_pkg::FN_UPCNT, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        $display("reset done");
    endtask

    // main sequence
    initial begin
        err_count = 0;
        n_compared = 0;
        srst = 1'b1;
        tick = 1'b0;
        func = 5'h00;
        par_a = 16'h0000;
        par_b = 16'h0000;
        par_c = 16'h0000;
        repeat (12) @(posedge clk);
        #1;
        check(result, 16'h0000);
        check({15'h0000, result_valid}, 16'h0000);
        srst = 1'b0;
        test_logic();
        test_clamp_select();
        test_bits();
        test_timer();
        test_smoother();
        test_regulator();
        test_counters();
        test_reset();
        close_out();
    end
endmodule
